/* src/pms_scanner.sv */
// Program memory scanner top: registers, fetch sequencer, CRC hand-off
//
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pms_scanner #(
    parameter int          NTRIG       = pms_pkg::PMS_NUM_TRIG,
    parameter logic [16:0] FLASH_WORDS = pms_pkg::PMS_FLASH_WORDS
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    input  wire logic             ce_i,
    input  wire logic             hsel_i,
    input  wire logic [11:0]      haddr_i,
    input  wire logic [1:0]       htrans_i,
    input  wire logic             hwrite_i,
    input  wire logic [2:0]       hsize_i,
    input  wire logic [31:0]      hwdata_i,
    input  wire logic             hready_i,
    output logic [31:0]           hrdata_o,
    output logic                  hreadyout_o,
    output logic                  hresp_o,
    input  wire logic             crc_ready_i,
    output logic                  crc_valid_o,
    output logic [15:0]           crc_data_o,
    output logic                  flash_req_o,
    output logic [15:0]           flash_addr_o,
    input  wire logic             flash_ack_i,
    input  wire logic [15:0]      flash_data_i,
    input  wire logic             irq_active_i,
    input  wire logic             debug_halt_i,
    input  wire logic [NTRIG-1:0] trig_src_i,
    output logic                  cpu_stall_o,
    output logic                  irq_o
);
    import pms_pkg::*;

    logic        en_reg;
    logic        go_reg;
    logic        prio_reg;
    logic [1:0]  mode_reg;
    logic [15:0] cur_reg;
    logic [15:0] end_reg;
    logic [3:0]  pacing_source_select_reg;
    logic        flag_reg;
    logic        ie_reg;
    logic        pend_reg;
    pms_state_t  state_reg;
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic        run_ce;
    logic        eff_go;
    logic        past_end;
    logic        done;
    logic        invalid;
    logic        busy;
    logic        trig_evt;
    logic        start;
    logic [7:0]  wb;
    logic [7:0]  ctrl_rd;

    // Debug halt freezes scanner state but not cpu_stall_o and irq_o; bus still works
    assign run_ce = ce_i & ~debug_halt_i; // [RQ18]
    assign wb     = hwdata_i[7:0];

    pms_ahb_slave u_bus (
        .mclk_i   (mclk_i),
        .rst_n_i  (rst_n_i),
        .ce_i     (ce_i),
        .hsel_i   (hsel_i),
        .haddr_i  (haddr_i),
        .htrans_i (htrans_i),
        .hwrite_i (hwrite_i),
        .hready_i (hready_i),
        .wr_o     (wr),
        .rd_o     (rd),
        .addr_o   (addr)
    );

    pms_trig_sel #(.N(NTRIG)) u_trig (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (run_ce),
        .clr_i   (~en_reg),
        .src_i   (trig_src_i),
        .sel_i   (pacing_source_select_reg),
        .evt_o   (trig_evt)
    );

    // Interrupt suppression; peek mode ignores priority select
    assign eff_go = go_reg & en_reg &
                    ~(prio_reg & irq_active_i & (mode_reg != PMS_MODE_PEEK)); // [RQ5] [RQ8] [RQ10] [RQ17]
    assign past_end = cur_reg > end_reg;
    assign done     = go_reg & past_end & (state_reg == PMS_IDLE); // [RQ4]
    assign invalid  = {1'b0, cur_reg} >= FLASH_WORDS; // [RQ7]
    assign busy     = (state_reg != PMS_IDLE) | (go_reg & crc_ready_i); // [RQ6]
    // Triggered mode paces one fetch per event
    assign start = eff_go & ~past_end & crc_ready_i & (state_reg == PMS_IDLE) &
                   ((mode_reg != PMS_MODE_TRIG) | trig_evt | pend_reg); // [RQ3] [RQ20]

    // Control register
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_reg   <= 1'b0;
            go_reg   <= 1'b0;
            prio_reg <= 1'b0;
            mode_reg <= PMS_MODE_CONC;
        end else if (ce_i) begin
            if (wr && addr == PMS_OFS_CTRL) begin
                en_reg   <= wb[PMS_B_EN];
                go_reg   <= wb[PMS_B_GO] & wb[PMS_B_EN];
                prio_reg <= wb[PMS_B_PRIO];
                mode_reg <= wb[1:0]; // [RQ11]
            end else if (!en_reg) begin
                go_reg <= 1'b0; // [RQ1]
            end else if (run_ce && done) begin
                go_reg <= 1'b0; // [RQ4]
            end
        end
    end

    // Address registers; locked while run request set
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cur_reg <= {PMS_RST_BYTE, PMS_RST_BYTE};
            end_reg <= {PMS_RST_BYTE, PMS_RST_BYTE};
        end else if (ce_i) begin
            if (wr && !go_reg) begin // [RQ13] [RQ15]
                if (addr == PMS_OFS_CURH) cur_reg[15:8] <= wb; // [RQ12]
                if (addr == PMS_OFS_CURL) cur_reg[7:0]  <= wb;
                if (addr == PMS_OFS_ENDH) end_reg[15:8] <= wb; // [RQ14]
                if (addr == PMS_OFS_ENDL) end_reg[7:0]  <= wb;
            end else if (run_ce && en_reg && state_reg == PMS_FETCH && flash_ack_i) begin
                cur_reg <= cur_reg + 16'h0001; // [RQ12]
            end
        end
    end

    // Trigger select and interrupt enable survive scanner disable
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pacing_source_select_reg <= 4'h0;
            ie_reg   <= 1'b0;
        end else if (ce_i && wr) begin
            if (addr == PMS_OFS_TRIG) pacing_source_select_reg <= wb[3:0]; // [RQ2] [RQ16]
            if (addr == PMS_OFS_IRQ)  ie_reg   <= wb[PMS_B_IE];
        end
    end

    // Scan-complete flag: set beats software clear
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_reg <= 1'b0;
        end else if (ce_i) begin
            if (run_ce && en_reg && done) begin
                flag_reg <= 1'b1; // [RQ19]
            end else if (wr && addr == PMS_OFS_IRQ && !wb[PMS_B_FLAG]) begin
                flag_reg <= 1'b0;
            end
        end
    end

    // Pending trigger event waits for CRC ready
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_reg <= 1'b0;
        end else if (run_ce) begin
            if (!en_reg || mode_reg != PMS_MODE_TRIG) begin
                pend_reg <= 1'b0;
            end else if (start) begin
                pend_reg <= 1'b0; // [RQ20]
            end else if (trig_evt) begin
                pend_reg <= 1'b1;
            end
        end
    end

    // Fetch sequencer
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg    <= PMS_IDLE;
            flash_req_o  <= 1'b0;
            flash_addr_o <= 16'h0000;
            crc_valid_o  <= 1'b0;
            crc_data_o   <= 16'h0000;
        end else if (run_ce) begin
            if (!en_reg) begin
                state_reg   <= PMS_IDLE; // [RQ1]
                flash_req_o <= 1'b0;
                crc_valid_o <= 1'b0;
            end else begin
                case (state_reg)
                    PMS_IDLE: begin
                        crc_valid_o <= 1'b0;
                        if (start) begin
                            state_reg    <= PMS_FETCH; // [RQ3]
                            flash_req_o  <= 1'b1;
                            flash_addr_o <= cur_reg;
                        end
                    end
                    PMS_FETCH: begin
                        if (flash_ack_i) begin
                            state_reg   <= PMS_SEND;
                            flash_req_o <= 1'b0;
                            crc_valid_o <= 1'b1;
                            crc_data_o  <= flash_data_i;
                        end
                    end
                    PMS_SEND: begin
                        crc_valid_o <= 1'b0;
                        state_reg   <= PMS_IDLE;
                    end
                    default: begin
                        state_reg <= PMS_IDLE;
                    end
                endcase
            end
        end
    end

    // Burst stall and interrupt output registered
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cpu_stall_o <= 1'b0;
            irq_o       <= 1'b0;
        end else if (ce_i) begin
            cpu_stall_o <= eff_go & ~done & (mode_reg == PMS_MODE_BURST); // [RQ9]
            irq_o       <= flag_reg & ie_reg; // [RQ19]
        end
    end

    always_comb begin
        ctrl_rd = {en_reg, go_reg, busy, invalid, prio_reg, 1'b0, mode_reg};
    end

    // Read data and fixed OKAY, zero-wait answer
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else if (ce_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            if (hsel_i && hready_i && htrans_i[1] && !hwrite_i) begin
                case (haddr_i)
                    PMS_OFS_CTRL: hrdata_o <= {24'h0, ctrl_rd};
                    PMS_OFS_CURH: hrdata_o <= {24'h0, cur_reg[15:8]};
                    PMS_OFS_CURL: hrdata_o <= {24'h0, cur_reg[7:0]};
                    PMS_OFS_ENDH: hrdata_o <= {24'h0, end_reg[15:8]};
                    PMS_OFS_ENDL: hrdata_o <= {24'h0, end_reg[7:0]};
                    PMS_OFS_TRIG: hrdata_o <= {28'h0, pacing_source_select_reg};
                    PMS_OFS_IRQ:  hrdata_o <= {30'h0, ie_reg, flag_reg};
                    default:      hrdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    property p_stop_past_end;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && !debug_halt_i && en_reg && done && !wr) |=> !go_reg;
    endproperty
    a_stop_past_end: assert property (p_stop_past_end) else $error("run not cleared"); // [RQ4]

    property p_disable_idle;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && !debug_halt_i && !en_reg) |=> (state_reg == PMS_IDLE && !flash_req_o);
    endproperty
    a_disable_idle: assert property (p_disable_idle) else $error("not idle when off"); // [RQ1]

    property p_addr_lock;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && go_reg && state_reg == PMS_IDLE) |=> $stable(end_reg);
    endproperty
    a_addr_lock: assert property (p_addr_lock) else $error("end changed while running"); // [RQ13]

    sequence s_fetch_ack;
        (state_reg == PMS_FETCH && flash_ack_i && ce_i && !debug_halt_i && en_reg);
    endsequence
    property p_incr;
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_fetch_ack ##0 (!wr || go_reg) |=> cur_reg == $past(cur_reg) + 16'h0001;
    endproperty
    a_incr: assert property (p_incr) else $error("address not incremented"); // [RQ12]

    property p_send;
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_fetch_ack |=> crc_valid_o && crc_data_o == $past(flash_data_i);
    endproperty
    a_send: assert property (p_send) else $error("word not delivered"); // [RQ3]

    property p_suppress;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (prio_reg && irq_active_i && mode_reg != PMS_MODE_PEEK) |-> !start;
    endproperty
    a_suppress: assert property (p_suppress) else $error("fetch during interrupt"); // [RQ5]

    property p_freeze;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (debug_halt_i && !wr) |=> $stable(cur_reg) && $stable(state_reg);
    endproperty
    a_freeze: assert property (p_freeze) else $error("moved in halt"); // [RQ18]

    property p_flag;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && !debug_halt_i && en_reg && done) |=> flag_reg ##1 (irq_o == ie_reg || !ce_i);
    endproperty
    a_flag: assert property (p_flag) else $error("complete flag missing"); // [RQ19]

    property p_busy;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (state_reg != PMS_IDLE || (go_reg && crc_ready_i)) |-> ctrl_rd[PMS_B_BUSY];
    endproperty
    a_busy: assert property (p_busy) else $error("busy not shown"); // [RQ6]

    property p_invalid;
        @(posedge mclk_i) disable iff (!rst_n_i)
        ({1'b0, cur_reg} >= FLASH_WORDS) |-> ctrl_rd[PMS_B_INVALID];
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid not shown"); // [RQ7]

    property p_stall;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && mode_reg == PMS_MODE_BURST && go_reg && en_reg && !irq_active_i && !done)
            |=> cpu_stall_o;
    endproperty
    a_stall: assert property (p_stall) else $error("burst without stall"); // [RQ9]

    property p_peek;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (mode_reg == PMS_MODE_PEEK && go_reg && en_reg && !past_end && crc_ready_i &&
         state_reg == PMS_IDLE) |-> start;
    endproperty
    a_peek: assert property (p_peek) else $error("peek held off"); // [RQ8]

    property p_trig_gate;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (mode_reg == PMS_MODE_TRIG && !trig_evt && !pend_reg) |-> !start;
    endproperty
    a_trig_gate: assert property (p_trig_gate) else $error("fetch without event"); // [RQ20]

    property p_keep_go;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (ce_i && go_reg && en_reg && state_reg != PMS_IDLE && !wr) |=> go_reg;
    endproperty
    a_keep_go: assert property (p_keep_go) else $error("run cleared mid transfer"); // [RQ4]
endmodule // pms_scanner
`default_nettype wire

/* src/pms_pkg.sv */
// Package for the program memory scanner: register map, fields, modes
// Behaviour
// [RQ1] Clearing enable stops scanner and resets its state machines and counters.
// [RQ2] Clearing enable leaves addresses, trigger select and other registers unchanged.
// [RQ3] While run request set, fetch word at current address when CRC ready.
// [RQ4] Hardware clears run request when current exceeds end and no transfer active.
// [RQ5] Interrupt priority select forces effective run request low during interrupts.
// [RQ6] Busy reads one while flash accessed or CRC ready, else zero. The code counts CRC ready only while the run request is set.
// [RQ7] Invalid flag set while current address lies beyond implemented flash.
// [RQ8] Peek mode ignores the interrupt priority select bit.
// [RQ9] Burst mode stalls CPU until done; interrupt handling per priority select.
// [RQ10] Concurrent and triggered modes suppress run request during interrupts when set.
// [RQ11] Mode field: 00 concurrent, 01 burst, 10 peek, 11 triggered.
// [RQ12] Sixteen-bit current address in two bytes, incremented after each fetch.
// [RQ13] Address register writes ignored while run request is set.
// [RQ14] Sixteen-bit end address in two bytes marks last scanned location.
// [RQ15] Software touches address bytes only while run request is clear.
// [RQ16] Four-bit pacing source select picks triggered-mode event; 1010-1111 reserved.
// [RQ17] Priority select clear: scan beats interrupts; set: interrupts beat scan.
// [RQ18] Scanner freezes on debug halt until normal operation resumes.
// [RQ19] Scan-complete flag set when hardware clears run request; gated interrupt.
// [RQ20] Triggered mode fetches once per selected trigger event, when CRC ready.
package pms_pkg;
    localparam logic [11:0] PMS_OFS_CTRL   = 12'h000;
    localparam logic [11:0] PMS_OFS_CURH   = 12'h004;
    localparam logic [11:0] PMS_OFS_CURL   = 12'h008;
    localparam logic [11:0] PMS_OFS_ENDH   = 12'h00c;
    localparam logic [11:0] PMS_OFS_ENDL   = 12'h010;
    localparam logic [11:0] PMS_OFS_TRIG   = 12'h014;
    localparam logic [11:0] PMS_OFS_IRQ    = 12'h018;
    localparam int          PMS_B_EN       = 7;
    localparam int          PMS_B_GO       = 6;
    localparam int          PMS_B_BUSY     = 5;
    localparam int          PMS_B_INVALID  = 4;
    localparam int          PMS_B_PRIO     = 3;
    localparam int          PMS_B_FLAG     = 0;
    localparam int          PMS_B_IE       = 1;
    localparam logic [7:0]  PMS_RST_BYTE   = 8'h00;
    localparam logic [1:0]  PMS_MODE_CONC  = 2'h0;
    localparam logic [1:0]  PMS_MODE_BURST = 2'h1;
    localparam logic [1:0]  PMS_MODE_PEEK  = 2'h2;
    localparam logic [1:0]  PMS_MODE_TRIG  = 2'h3;
    localparam int          PMS_NUM_TRIG   = 10;
    localparam logic [16:0] PMS_FLASH_WORDS = 17'h00800;
    typedef enum logic [2:0] {
        PMS_IDLE  = 3'b001,
        PMS_FETCH = 3'b010,
        PMS_SEND  = 3'b100
    } pms_state_t;
endpackage

/* src/pms_trig_sel.sv */
// Pacing source selector with rising-edge pulse out
`timescale 1ns/1ps
`default_nettype none
module pms_trig_sel #(
    parameter int N = 10
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    input  wire logic         clr_i,
    input  wire logic [N-1:0] src_i,
    input  wire logic [3:0]   sel_i,
    output logic              evt_o
);
    logic [N-1:0] prev_reg;
    logic [N-1:0] rise;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_src
            assign rise[g] = src_i[g] & ~prev_reg[g];
        end
    endgenerate
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_reg <= '0;
        end else if (ce_i) begin
            prev_reg <= src_i;
        end
    end
    // Reserved selections never produce an event
    assign evt_o = (sel_i < 4'(N)) ? rise[sel_i] & ~clr_i : 1'b0; // [RQ16]
endmodule // pms_trig_sel
`default_nettype wire

/* src/pms_ahb_slave.sv */
// AHB-Lite slave front end: captures address phase, zero-wait answer
`timescale 1ns/1ps
`default_nettype none
module pms_ahb_slave (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        hsel_i,
    input  wire logic [11:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic        hready_i,
    output logic             wr_o,
    output logic             rd_o,
    output logic [11:0]      addr_o
);
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_o   <= 1'b0;
            rd_o   <= 1'b0;
            addr_o <= 12'h000;
        end else if (ce_i) begin
            wr_o   <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
            rd_o   <= hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
            addr_o <= haddr_i;
        end
    end
endmodule // pms_ahb_slave
`default_nettype wire

/* bench/pms_far_model.sv */
// Far-side model: program flash with variable latency and CRC ready line
`timescale 1ns/1ps
`default_nettype none
module pms_far_model (
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        req_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [1:0]  lat_i,
    input  wire logic        stall_i,
    output logic             ack_o,
    output logic [15:0]      data_o,
    output logic             ready_o
);
    logic [1:0] wait_reg;

    assign ready_o = !stall_i;

    // Data toggles outside an ack, so a sample one cycle late never matches
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_reg <= 2'h0;
            ack_o    <= 1'b0;
            data_o   <= 16'h0000;
        end else begin
            ack_o  <= 1'b0;
            data_o <= ~data_o;
            if (req_i && !ack_o) begin
                if (wait_reg >= lat_i) begin
                    ack_o    <= 1'b1;
                    data_o   <= {addr_i[7:0], ~addr_i[15:8]} ^ 16'h1234;
                    wait_reg <= 2'h0;
                end else begin
                    wait_reg <= wait_reg + 2'h1;
                end
            end
        end
    end
endmodule // pms_far_model
`default_nettype wire

/* bench/program_memory_scanner_tb.sv */
// Self-checking bench for the program memory scanner
`timescale 1ns/1ps
`default_nettype none
module program_memory_scanner_tb;
    import pms_pkg::*;
    logic        mclk_i = 1'b0, rst_n_i = 1'b0, hwrite = 1'b0, hrdy, hresp;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0, lat = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata;
    logic        crc_rdy, crc_vld, freq, fack, stall, irq, irqa = 1'b0, dbg = 1'b0;
    logic        crc_stall = 1'b0;
    logic [15:0] crc_data, faddr, fdata;
    logic [9:0]  trig = 10'h000;
    logic [15:0] got_q[$], exp_q[$];
    logic [31:0] r;
    bit          stall_seen;
    int          n_errors = 0, cmp_count = 0, k;

    pms_scanner i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .hsel_i(1'b1),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
        .hresp_o(hresp), .crc_ready_i(crc_rdy), .crc_valid_o(crc_vld),
        .crc_data_o(crc_data), .flash_req_o(freq), .flash_addr_o(faddr),
        .flash_ack_i(fack), .flash_data_i(fdata), .irq_active_i(irqa),
        .debug_halt_i(dbg), .trig_src_i(trig), .cpu_stall_o(stall), .irq_o(irq));
    pms_far_model i_far (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(freq), .addr_i(faddr),
        .lat_i(lat), .stall_i(crc_stall), .ack_o(fack), .data_o(fdata), .ready_o(crc_rdy));

    always #20 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        crc_stall <= ($urandom_range(3) == 0);
        lat <= 2'($urandom_range(3));
        if (crc_vld === 1'b1) got_q.push_back(crc_data);
        if (stall === 1'b1) stall_seen = 1'b1;
    end

    function automatic logic [15:0] word(input logic [15:0] a);
        return {a[7:0], ~a[15:8]} ^ 16'h1234;
    endfunction
    task automatic end_sim;
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge mclk_i);
            if (++n > 50) begin
                n_errors++;
                end_sim();
            end
        end while (hrdy !== 1'b1);
    endtask
    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
        chk("hresp", 32'h0, 32'(hresp));
    endtask
    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        chk(nm, e, r);
    endtask

    task automatic do_scan(input logic [1:0] m, input logic p, input int hold,
                           input logic [15:0] s, input int n);
        logic [15:0] e;
        logic [16:0] nx;
        logic [3:0]  sel;
        e = s + 16'(n - 1);
        nx = {1'b0, e} + 17'h1;
        sel = 4'($urandom_range(9));
        got_q.delete();
        exp_q.delete();
        stall_seen = 1'b0;
        for (int i = 0; i < n; i++) exp_q.push_back(word(s + 16'(i)));
        bus(PMS_OFS_CURH, 1'b1, {24'h0, s[15:8]});
        bus(PMS_OFS_CURL, 1'b1, {24'h0, s[7:0]});
        bus(PMS_OFS_ENDH, 1'b1, {24'h0, e[15:8]});
        bus(PMS_OFS_ENDL, 1'b1, {24'h0, e[7:0]});
        bus(PMS_OFS_TRIG, 1'b1, {28'h0, sel});
        bus(PMS_OFS_IRQ, 1'b1, 32'h2);
        bus(PMS_OFS_CTRL, 1'b1, 32'h80);
        irqa <= (hold == 1);
        dbg <= (hold == 2);
        bus(PMS_OFS_CTRL, 1'b1, {24'h0, 4'hc, p, 1'b0, m});
        bus(PMS_OFS_CURL, 1'b1, 32'hff);
        bus(PMS_OFS_ENDL, 1'b1, 32'hff);
        if (m == PMS_MODE_TRIG) chk("no event no fetch", 32'h0, 32'(got_q.size()));
        if (hold == 2 || (hold == 1 && p && m != PMS_MODE_PEEK)) begin
            repeat (30) @(posedge mclk_i);
            chk("words while held", 32'h0, 32'(got_q.size()));
            bus(PMS_OFS_CTRL, 1'b0, 32'h0);
            chk("run kept", {24'h0, 4'hc, p, 1'b0, m}, r & 32'hdf);
            irqa <= 1'b0;
            dbg <= 1'b0;
        end
        for (k = 0; k < 400; k++) begin
            if (k > 300) begin
                n_errors++;
                end_sim();
            end
            trig[sel] <= 1'b1;
            @(posedge mclk_i);
            trig <= 10'h000;
            if (m == PMS_MODE_TRIG) chk("one per event", 32'h1, 32'(got_q.size() <= k + 1));
            bus(PMS_OFS_CTRL, 1'b0, 32'h0);
            if (r[PMS_B_GO] === 1'b0) break;
        end
        irqa <= 1'b0;
        chk("word count", 32'(exp_q.size()), 32'(got_q.size()));
        foreach (exp_q[i]) chk("crc word", {16'h0, exp_q[i]}, {16'h0, got_q[i]});
        chk("cpu stall", 32'(m == PMS_MODE_BURST), 32'(stall_seen));
        chk("ctrl done", {24'h0, 3'h4, nx >= PMS_FLASH_WORDS, p, 1'b0, m}, r & 32'hdf);
        rd_chk("cur high", PMS_OFS_CURH, {24'h0, nx[15:8]});
        rd_chk("cur low", PMS_OFS_CURL, {24'h0, nx[7:0]});
        rd_chk("end low", PMS_OFS_ENDL, {24'h0, e[7:0]});
        chk("irq", 32'h1, 32'(irq));
        rd_chk("flag", PMS_OFS_IRQ, 32'h3);
        bus(PMS_OFS_IRQ, 1'b1, 32'h2);
        rd_chk("flag clear", PMS_OFS_IRQ, 32'h2);
        chk("irq clear", 32'h0, 32'(irq));
    endtask

    initial begin
        void'($urandom(27488));
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        for (int a = 0; a < 8; a++) rd_chk("reset value", 12'(a * 4), 32'h0);
        bus(12'h01c, 1'b1, 32'hff);
        rd_chk("unmapped", 12'h01c, 32'h0);
        bus(PMS_OFS_CTRL, 1'b1, 32'h40);
        rd_chk("run needs enable", PMS_OFS_CTRL, 32'h0);
        bus(PMS_OFS_TRIG, 1'b1, 32'hff);
        rd_chk("trig mask", PMS_OFS_TRIG, 32'h0f);
        for (int m = 0; m < 4; m++)
            do_scan(2'(m), 1'b0, 0, 16'($urandom_range(16'h07f0)), 2 + $urandom_range(3));
        do_scan(PMS_MODE_CONC, 1'b1, 1, 16'h0040, 3);
        do_scan(PMS_MODE_CONC, 1'b0, 1, 16'h0050, 3);
        do_scan(PMS_MODE_PEEK, 1'b1, 1, 16'h0060, 3);
        do_scan(PMS_MODE_BURST, 1'b1, 1, 16'h0070, 3);
        do_scan(PMS_MODE_BURST, 1'b0, 1, 16'h0078, 2);
        do_scan(PMS_MODE_TRIG, 1'b1, 1, 16'h0088, 3);
        do_scan(PMS_MODE_TRIG, 1'b0, 2, 16'h0080, 3);
        do_scan(PMS_MODE_CONC, 1'b0, 0, 16'h07fe, 2);
        got_q.delete();
        bus(PMS_OFS_CURH, 1'b1, 32'h01);
        bus(PMS_OFS_CURL, 1'b1, 32'h00);
        bus(PMS_OFS_ENDL, 1'b1, 32'h3f);
        bus(PMS_OFS_ENDH, 1'b1, 32'h01);
        bus(PMS_OFS_TRIG, 1'b1, 32'h05);
        bus(PMS_OFS_CTRL, 1'b1, 32'h80);
        bus(PMS_OFS_CTRL, 1'b1, 32'hc0);
        repeat (20) @(posedge mclk_i);
        bus(PMS_OFS_CTRL, 1'b1, 32'h00);
        repeat (4) @(posedge mclk_i);
        k = got_q.size();
        repeat (20) @(posedge mclk_i);
        chk("halted by disable", 32'(k), 32'(got_q.size()));
        rd_chk("ctrl disabled", PMS_OFS_CTRL, 32'h0);
        rd_chk("end kept", PMS_OFS_ENDL, 32'h3f);
        rd_chk("trig kept", PMS_OFS_TRIG, 32'h05);
        end_sim();
    end
endmodule // program_memory_scanner_tb
`default_nettype wire
